// [design/sep_eeprom_core.sv]
`timescale 1ns/1ps
module sep_eeprom_core #(
    parameter int TWC_CYCLES = sep_pkg::TWC_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       pause_n,
    input  wire logic       guard_n,
    output logic            so_out,
    output logic            so_oe_n,
    output logic [7:0]      status_view
);
    import sep_pkg::*;

    sep_link_if lnk();

    sep_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .pause_n (pause_n),
        .guard_n (guard_n),
        .lnk     (lnk)
    );

    // Arrays held here; nonvolatile cell timing is modelled by the busy counter only
    logic [7:0]            mem_q [0:(1<<MEM_AW)-1];
    logic [7:0]            idp_q [0:PAGE_BYTES-1];
    logic [7:0]            pbuf_q [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pval_q;

    sep_state_t            st_q;
    logic [7:0]            sh_q;
    logic [2:0]            bit_q;
    logic [4:0]            acnt_q;
    logic [ADDR_BITS-1:0]  addr_q;
    logic [7:0]            op_q;
    logic                  opc_done_q;
    logic                  whole_q;
    logic                  data_seen_q;
    logic                  cmd_drop_q;
    logic [7:0]            srw_q;
    logic                  srw_abort_q;
    logic [7:0]            tx_q;
    logic                  so_q;
    logic                  pge_q;
    logic                  ips_q;
    logic                  idl_q;
    logic [1:0]            bg_q;
    logic                  wlf_q;
    logic                  busy_q;
    logic                  prog_page_q;
    logic                  prog_sr_q;
    logic                  prog_idp_q;
    logic [31:0]           twc_q;
    logic [MEM_AW-1:0]     page_base_q;

    wire  shift_in  = lnk.sck_rise & ~lnk.paused;
    wire  byte_end  = shift_in & (bit_q == 3'h7);
    wire  [7:0] sh_next = {sh_q[6:0], lnk.si};
    wire  [7:0] sr_view = {pge_q, ips_q, 1'b0, idl_q, bg_q, wlf_q, busy_q};
    wire  sr_locked = pge_q & ~lnk.guard_pin_n;

    // Block guard coverage of a main-array address, largest density
    function automatic logic guarded(input logic [1:0] bg, input logic [MEM_AW-1:0] a);
        logic r;
        r = 1'b1;
        if (bg == BG_NONE)
            r = 1'b0;
        else if (bg == BG_QUARTER)
            r = (a[MEM_AW-1:MEM_AW-2] == 2'h3);
        else if (bg == BG_HALF)
            r = a[MEM_AW-1];
        return r;
    endfunction

    // Id page index measured against the same quarter/half split of its 32 bytes
    function automatic logic idp_guarded(input logic [1:0] bg, input logic [PAGE_AW-1:0] a);
        logic r;
        r = 1'b1;
        if (bg == BG_NONE)
            r = 1'b0;
        else if (bg == BG_QUARTER)
            r = (a[PAGE_AW-1:PAGE_AW-2] == 2'h3);
        else if (bg == BG_HALF)
            r = a[PAGE_AW-1];
        return r;
    endfunction

    // Serial front: bit counter and shift register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sh_q  <= 8'h00;
            bit_q <= 3'h0;
        end else if (lnk.cs_fall) begin
            bit_q <= 3'h0;
        end else if (shift_in) begin
            sh_q  <= sh_next;
            bit_q <= bit_q + 3'h1;
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q        <= ST_OPC;
            op_q        <= 8'h00;
            acnt_q      <= 5'h00;
            addr_q      <= '0;
            opc_done_q  <= 1'b0;
            whole_q     <= 1'b1;
            data_seen_q <= 1'b0;
            srw_q       <= 8'h00;
            cmd_drop_q  <= 1'b0;
            pval_q      <= '0;
        end else if (lnk.cs_fall) begin
            st_q        <= ST_OPC;
            acnt_q      <= 5'h00;
            opc_done_q  <= 1'b0;
            whole_q     <= 1'b1;
            data_seen_q <= 1'b0;
            cmd_drop_q  <= 1'b0;
            pval_q      <= '0;
        end else if (shift_in) begin
            whole_q <= byte_end;
            case (st_q)
                ST_OPC: begin
                    if (byte_end) begin
                        op_q       <= sh_next;
                        opc_done_q <= 1'b1;
                        // Dropped for the whole frame, even if busy ends before select rises
                        if (busy_q && sh_next != OP_SR_RD) begin
                            st_q       <= ST_IGNORE;
                            cmd_drop_q <= 1'b1;
                        end
                        else if (sh_next == OP_READ || sh_next == OP_WRITE)
                            st_q <= ST_ADDR;
                        else if (sh_next == OP_SR_WR)
                            st_q <= ST_SRW;
                        else if (sh_next == OP_SR_RD)
                            st_q <= ST_SRRD;
                        else if (sh_next == OP_ARM || sh_next == OP_DISARM)
                            st_q <= ST_IGNORE;
                        else
                            st_q <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[ADDR_BITS-2:0], lnk.si};
                    acnt_q <= acnt_q + 5'h1;
                    if (acnt_q == 5'(ADDR_BITS - 1))
                        st_q <= (op_q == OP_READ) ? ST_RDATA : ST_DATA;
                end
                ST_DATA: begin
                    if (byte_end && !wlf_q)
                        st_q <= ST_IGNORE;
                    else if (byte_end) begin
                        pbuf_q[addr_q[PAGE_AW-1:0]] <= sh_next;
                        pval_q[addr_q[PAGE_AW-1:0]] <= 1'b1;
                        addr_q[PAGE_AW-1:0] <= addr_q[PAGE_AW-1:0] + 5'h1;
                        data_seen_q <= 1'b1;
                    end
                end
                ST_SRW: begin
                    if (byte_end) begin
                        srw_q       <= sh_next;
                        data_seen_q <= 1'b1;
                        st_q        <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (byte_end)
                        addr_q <= addr_q + 16'h0001;
                end
                ST_IGNORE: begin
                    data_seen_q <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // Guard pin dropping mid status write kills it when status bit SR_PGE is set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            srw_abort_q <= 1'b0;
        else if (lnk.cs_fall)
            srw_abort_q <= 1'b0;
        else if (lnk.cs_active && op_q == OP_SR_WR && opc_done_q && sr_locked)
            srw_abort_q <= 1'b1;
    end

    wire seq_ok   = opc_done_q & whole_q & ~busy_q & ~cmd_drop_q;
    wire go_arm   = lnk.cs_rise & seq_ok & (op_q == OP_ARM) & (st_q == ST_IGNORE) & ~data_seen_q;
    wire go_dis   = lnk.cs_rise & seq_ok & (op_q == OP_DISARM);
    wire go_write = lnk.cs_rise & seq_ok & (op_q == OP_WRITE) & (st_q == ST_DATA) & data_seen_q & wlf_q;
    wire go_srw   = lnk.cs_rise & seq_ok & (op_q == OP_SR_WR) & data_seen_q & wlf_q & ~srw_abort_q & ~sr_locked;
    wire rd_done  = lnk.cs_rise & (st_q == ST_RDATA);

    // Status bits and write cycle timer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wlf_q       <= 1'b0;
            busy_q      <= 1'b0;
            twc_q       <= '0;
            prog_page_q <= 1'b0;
            prog_sr_q   <= 1'b0;
            prog_idp_q  <= 1'b0;
            page_base_q <= '0;
        end else if (busy_q) begin
            if (twc_q == 32'(TWC_CYCLES - 1)) begin
                busy_q      <= 1'b0;
                wlf_q       <= 1'b0;
                prog_page_q <= 1'b0;
                prog_sr_q   <= 1'b0;
                prog_idp_q  <= 1'b0;
            end else
                twc_q <= twc_q + 32'h1;
        end else if (go_arm) begin
            wlf_q <= 1'b1;
        end else if (go_dis) begin
            wlf_q <= 1'b0;
        end else if (go_write || go_srw) begin
            busy_q      <= 1'b1;
            twc_q       <= '0;
            prog_page_q <= go_write & ~ips_q;
            prog_idp_q  <= go_write & ips_q;
            prog_sr_q   <= go_srw;
            page_base_q <= {addr_q[MEM_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
        end
    end

    // Configuration bits, committed at start of the status write cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pge_q <= 1'b0;
            ips_q <= 1'b0;
            idl_q <= 1'b0;
            bg_q  <= BG_NONE;
        end else if (go_srw) begin
            pge_q <= srw_q[SR_PGE];
            bg_q  <= srw_q[SR_BGH:SR_BGL];
            if (!(srw_q[SR_IPS] && srw_q[SR_IDL])) begin
                ips_q <= srw_q[SR_IPS];
                idl_q <= idl_q | srw_q[SR_IDL];
            end
        end else if (rd_done || go_write) begin
            ips_q <= 1'b0;
        end
    end

    // Commit loaded page into the selected array per byte
    // Main array written from one process so it keeps a single driver
    always_ff @(posedge ref_clk) begin
        if (busy_q && twc_q == 32'h0 && prog_page_q) begin
            for (int k = 0; k < PAGE_BYTES; k++) begin
                if (pval_q[k] && !guarded(bg_q, page_base_q | MEM_AW'(k)))
                    mem_q[page_base_q | MEM_AW'(k)] <= pbuf_q[k];
            end
        end
    end

    generate
        for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_commit
            always_ff @(posedge ref_clk) begin
                if (busy_q && twc_q == 32'h0 && pval_q[i] && prog_idp_q) begin
                    if (~&bg_q && !idl_q && !idp_guarded(bg_q, PAGE_AW'(i)))
                        idp_q[i] <= pbuf_q[i];
                end
            end
        end
    endgenerate

    // Output shifter: load at byte boundary, shift on falling edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_q <= 8'h00;
            so_q <= 1'b0;
        end else if (shift_in && ((st_q == ST_OPC && byte_end && sh_next == OP_SR_RD)
                                  || (st_q == ST_SRRD && byte_end))) begin
            tx_q <= sr_view;
        end else if (shift_in && st_q == ST_ADDR && acnt_q == 5'(ADDR_BITS - 1)) begin
            tx_q <= ips_q ? idp_q[sh_next[PAGE_AW-1:0] | PAGE_AW'({addr_q[PAGE_AW-2:0], 1'b0})]
                          : mem_q[{addr_q[MEM_AW-2:0], lnk.si}];
        end else if (shift_in && st_q == ST_RDATA && byte_end) begin
            tx_q <= ips_q ? idp_q[PAGE_AW'(addr_q[PAGE_AW-1:0] + 1'b1)]
                          : mem_q[MEM_AW'(addr_q[MEM_AW-1:0] + 1'b1)];
        end else if (lnk.sck_fall && !lnk.paused) begin
            so_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign so_out      = so_q;
    assign so_oe_n     = ~(lnk.cs_active & ~lnk.paused & (st_q == ST_SRRD || st_q == ST_RDATA));
    assign status_view = sr_view;

    ready_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(busy_q) |-> busy_q [*8]) else $error("busy dropped early");
    wlf_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(busy_q) |-> !wlf_q) else $error("latch kept after write");
    arm_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        go_arm && !busy_q |=> wlf_q) else $error("arm missed");
    disarm_a: assert property (@(posedge ref_clk) disable iff (rst)
        go_dis && !busy_q |=> !wlf_q) else $error("disarm missed");
    so_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        !lnk.cs_active |-> so_oe_n) else $error("output driven deselected");
    pause_hiz_a: assert property (@(posedge ref_clk) disable iff (rst)
        lnk.paused |-> so_oe_n) else $error("output driven in pause");
    srw_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
        sr_locked |-> !go_srw) else $error("status written while pin locked");
    no_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        !wlf_q |=> !$rose(busy_q)) else $error("write without latch");
    bit5_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        status_view[5] == 1'b0) else $error("bit 5 set");
endmodule

// [design/sep_link_if.sv]
`timescale 1ns/1ps
interface sep_link_if;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_active;
    logic       cs_fall;
    logic       cs_rise;
    logic       si;
    logic       paused;
    logic       guard_pin_n;
    modport front (output sck_rise, sck_fall, cs_active, cs_fall, cs_rise, si, paused, guard_pin_n);
    modport core  (input  sck_rise, sck_fall, cs_active, cs_fall, cs_rise, si, paused, guard_pin_n);
endinterface

// [design/sep_pin_sync.sv]
`timescale 1ns/1ps
module sep_pin_sync (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  cs_n,
    input  wire logic  sck,
    input  wire logic  si,
    input  wire logic  pause_n,
    input  wire logic  guard_n,
    sep_link_if.front  lnk
);
    // Two stages per pin, then a third for edge detection
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic       sck_d_q;
    logic       cs_d_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 5'h1c;
            s2_q <= 5'h1c;
        end else begin
            s1_q <= {cs_n, guard_n, pause_n, sck, si};
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_d_q <= 1'b0;
            cs_d_q  <= 1'b1;
        end else begin
            sck_d_q <= s2_q[1];
            cs_d_q  <= s2_q[4];
        end
    end

    assign lnk.si          = s2_q[0];
    assign lnk.paused      = ~s2_q[2] & ~s2_q[4];
    assign lnk.guard_pin_n = s2_q[3];
    assign lnk.cs_active   = ~s2_q[4];
    assign lnk.cs_fall     = cs_d_q & ~s2_q[4];
    assign lnk.cs_rise     = ~cs_d_q & s2_q[4];
    assign lnk.sck_rise    = ~sck_d_q & s2_q[1] & ~s2_q[4];
    assign lnk.sck_fall    = sck_d_q & ~s2_q[1] & ~s2_q[4];
endmodule

// [design/sep_pkg.sv]
// Operation
// - SPI slave modes 0 and 3, 8-bit opcode
// - Act only on six opcodes, ignore rest
// - Read opcode streams out stored bytes
// - Clock 16 address bits, use low 13
// - Arm only when select rises after opcode
// - Disarm opcode clears write latch flag
// - Power up with writes disabled
// - Program at select rise; busy ignores most
// - Busy flag shows write cycle, read only
// - Page load wraps within 32-byte page
// - Write cycle end clears write latch
// - Status register bit layout fixed
// - Status write changes bits 2,3,4,6,7 only
// - Block guard protects quarter, half, all
// - Write permission from latch, guard, pin
// - Guard pin low aborts pending status write
// - Id page select steers, then self-clears
// - Id page write index, lock and guard checks
// - Id page lock makes page read-only
// - Setting select and lock together ignored
// - Sample input on rise, drive on fall
// - Output released while select high
// - Pause releases output, ignores input
package sep_pkg;
    localparam logic [7:0] OP_ARM    = 8'h06;
    localparam logic [7:0] OP_DISARM = 8'h04;
    localparam logic [7:0] OP_SR_RD  = 8'h05;
    localparam logic [7:0] OP_SR_WR  = 8'h01;
    localparam logic [7:0] OP_READ   = 8'h03;
    localparam logic [7:0] OP_WRITE  = 8'h02;
    localparam int SR_PGE  = 7;
    localparam int SR_IPS  = 6;
    localparam int SR_IDL  = 4;
    localparam int SR_BGH  = 3;
    localparam int SR_BGL  = 2;
    localparam int SR_WLF  = 1;
    localparam int SR_BUSY = 0;
    localparam logic [7:0] SR_WR_MASK = 8'hdc;
    localparam logic [1:0] BG_NONE    = 2'h0;
    localparam logic [1:0] BG_QUARTER = 2'h1;
    localparam logic [1:0] BG_HALF    = 2'h2;
    localparam int ADDR_BITS  = 16;
    localparam int MEM_AW     = 13;
    localparam int PAGE_AW    = 5;
    localparam int PAGE_BYTES = 32;
    localparam int CLK_HZ     = 40_000_000;
    localparam int TWC_US     = 4000;
    localparam int TWC_CYC    = CLK_HZ / 1_000_000 * TWC_US;
    typedef enum logic [2:0] {
        ST_OPC, ST_ADDR, ST_DATA, ST_SRW, ST_SRRD, ST_RDATA, ST_IGNORE
    } sep_state_t;
endpackage

// [tb/sep_host.sv]
`timescale 1ns/1ps
module sep_host (
    input  wire logic  ref_clk,
    input  wire logic  so_out,
    input  wire logic  so_oe_n,
    output logic       cs_n,
    output logic       sck,
    output logic       si
);
    logic        last_q;
    logic        so_line;
    logic [63:0] rx;

    // Released line shows the inverse of its last level, so stale data cannot pass
    always @(posedge ref_clk) begin
        if (!so_oe_n) last_q <= so_out;
    end
    assign so_line = so_oe_n ? ~last_q : so_out;

    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
        rx   = 64'h0;
    end

    task automatic half();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // Bytes are left aligned in tx; sck pulses only inside a frame, its idle level is set before select falls
    task automatic frame(input logic [63:0] tx, input int n, input int extra, input logic mode3);
        int i;
        @(posedge ref_clk);
        #1;
        // Idle level settles before select falls, so no false first edge
        sck  = mode3;
        half();
        cs_n = 1'b0;
        half();
        for (i = 0; i < 8 * n + extra; i++) begin
            sck = 1'b0;
            si  = tx[63 - i];
            half();
            rx[63 - i] = so_line;
            sck = 1'b1;
            half();
        end
        sck = mode3;
        half();
        cs_n = 1'b1;
        si   = ~si;
        half();
    endtask
endmodule

// [tb/test_spi_eeprom_command_protect.sv]
`timescale 1ns/1ps
module test_spi_eeprom_command_protect;
    import sep_pkg::*;
    localparam int TWC = 500;

    typedef struct packed {
        logic [23:0] tx;
        logic [1:0]  n;
        logic [2:0]  extra;
        logic        mode3;
        logic        guard;
        logic [7:0]  exp;
    } sep_row_t;

    logic       ref_clk;
    logic       rst;
    logic       pause_n;
    logic       guard_n;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       so_out;
    logic       so_oe_n;
    logic [7:0] status_view;
    int         mismatches;
    int         checked;
    int         i;

    sep_row_t rows [10] = '{
        '{24'h060000, 2'h1, 3'h0, 1'h0, 1'h1, 8'h02},
        '{24'h040000, 2'h1, 3'h0, 1'h0, 1'h1, 8'h00},
        '{24'h018c00, 2'h2, 3'h0, 1'h0, 1'h1, 8'h00},
        '{24'h060000, 2'h1, 3'h1, 1'h0, 1'h1, 8'h00},
        '{24'h060000, 2'h1, 3'h0, 1'h1, 1'h1, 8'h02},
        '{24'h01ff00, 2'h2, 3'h0, 1'h0, 1'h1, 8'h8c},
        '{24'h060000, 2'h1, 3'h0, 1'h0, 1'h1, 8'h8e},
        '{24'h990000, 2'h1, 3'h0, 1'h0, 1'h1, 8'h8e},
        '{24'h010000, 2'h2, 3'h0, 1'h0, 1'h0, 8'h8e},
        '{24'h010000, 2'h2, 3'h0, 1'h0, 1'h1, 8'h00}
    };

    sep_eeprom_core #(.TWC_CYCLES(TWC)) sep_eeprom_core_inst (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .cs_n        (cs_n),
        .sck         (sck),
        .si          (si),
        .pause_n     (pause_n),
        .guard_n     (guard_n),
        .so_out      (so_out),
        .so_oe_n     (so_oe_n),
        .status_view (status_view)
    );

    sep_host sep_host_inst (
        .ref_clk (ref_clk),
        .so_out  (so_out),
        .so_oe_n (so_oe_n),
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si)
    );

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Status settles a few cycles after select rises, then busy is polled
    task automatic settle();
        int k;
        repeat (8) @(posedge ref_clk);
        for (k = 0; k < 1000 && status_view[SR_BUSY] !== 1'b0; k++) @(posedge ref_clk);
        #1;
    endtask

    task automatic run(input logic [63:0] tx, input int n, input int extra);
        sep_host_inst.frame(tx, n, extra, 1'b0);
        settle();
    endtask

    task automatic wr(input logic [63:0] tx, input int n);
        run(64'h0600000000000000, 1, 0);
        sep_host_inst.frame(tx, n, 0, 1'b0);
        repeat (8) @(posedge ref_clk);
        #1;
        check8({7'h0, status_view[SR_BUSY]}, 8'h01);
        settle();
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        run({8'h03, a, 40'h0}, 4, 0);
        check8(sep_host_inst.rx[39:32], exp);
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        mismatches = 0;
        checked    = 0;
        rst        = 1'b1;
        pause_n    = 1'b1;
        guard_n    = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check8(status_view, 8'h00);
        check8({7'h0, so_oe_n}, 8'h01);
        for (i = 0; i < 10; i++) begin
            guard_n = rows[i].guard;
            sep_host_inst.frame({rows[i].tx, 40'h0}, rows[i].n, rows[i].extra, rows[i].mode3);
            settle();
            check8(status_view, rows[i].exp);
        end
        wr(64'h02001fa55a000000, 5);
        check8(status_view, 8'h00);
        rd(16'h0000, 8'h5a);
        rd(16'he01f, 8'ha5);
        // Busy window: status read answers, disarming is ignored
        run(64'h0600000000000000, 1, 0);
        sep_host_inst.frame(64'h0200057700000000, 4, 0, 1'b0);
        sep_host_inst.frame(64'h0500000000000000, 2, 0, 1'b0);
        check8(sep_host_inst.rx[55:48], 8'h03);
        sep_host_inst.frame(64'h0400000000000000, 1, 0, 1'b0);
        repeat (8) @(posedge ref_clk);
        #1;
        check8(status_view, 8'h03);
        settle();
        check8(status_view, 8'h00);
        rd(16'h0005, 8'h77);
        wr(64'h0218003300000000, 4);
        run(64'h0600000000000000, 1, 0);
        run(64'h0104000000000000, 2, 0);
        run(64'h0600000000000000, 1, 0);
        run(64'h0218004400000000, 4, 0);
        check8(status_view, 8'h04);
        wr(64'h0217ff6600000000, 4);
        rd(16'h1800, 8'h33);
        rd(16'h17ff, 8'h66);
        run(64'h0600000000000000, 1, 0);
        run(64'h0100000000000000, 2, 0);
        run(64'h0600000000000000, 1, 0);
        run(64'h0200068800000000, 4, 3);
        check8(status_view, 8'h02);
        run(64'h0400000000000000, 1, 0);
        pause_n = 1'b0;
        run(64'h0600000000000000, 1, 0);
        pause_n = 1'b1;
        check8(status_view, 8'h00);
        run(64'h0600000000000000, 1, 0);
        run(64'h0140000000000000, 2, 0);
        run(64'h0500000000000000, 2, 0);
        check8(sep_host_inst.rx[55:48], 8'h40);
        wr(64'h020003bb00000000, 4);
        check8(status_view, 8'h00);
        run(64'h0600000000000000, 1, 0);
        run(64'h0140000000000000, 2, 0);
        rd(16'hffe3, 8'hbb);
        check8(status_view, 8'h00);
        check8({7'h0, so_oe_n}, 8'h01);
        // Guard pin pulse inside a status write frame, gone again before select rises
        run(64'h0600000000000000, 1, 0);
        run(64'h0180000000000000, 2, 0);
        run(64'h0600000000000000, 1, 0);
        fork
            sep_host_inst.frame(64'h0100000000000000, 2, 0, 1'b0);
            begin
                repeat (100) @(posedge ref_clk);
                #1;
                guard_n = 1'b0;
                repeat (20) @(posedge ref_clk);
                #1;
                guard_n = 1'b1;
            end
        join
        settle();
        check8(status_view, 8'h82);
        run(64'h0100000000000000, 2, 0);
        check8(status_view, 8'h00);
        // Reset in mid-run drops the latch
        run(64'h0600000000000000, 1, 0);
        check8(status_view, 8'h02);
        rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check8(status_view, 8'h00);
        check8({7'h0, so_oe_n}, 8'h01);
        tally_and_finish();
    end
endmodule
